// ==== logic/fsw_prot_range.sv ====
// Package of status layout and instruction codes, plus the array protect-range decoder.
// Assumes a 512KB array addressed by 19 bits and one synchronous clock domain.

package fsw_pkg;
    localparam int ADDR_W = 19;
    // Status word bit positions, low byte then high byte
    localparam int BIT_BUSY = 0;
    localparam int BIT_WLATCH = 1;
    localparam int BIT_RANGE_LO = 2;
    localparam int BIT_TOPBOT = 5;
    localparam int BIT_SMALLUNIT = 6;
    localparam int BIT_LOCK_LO = 7;
    localparam int BIT_LOCK_HI = 8;
    localparam int BIT_QUAD = 9;
    localparam int BIT_OTP_LO = 10;
    localparam int BIT_COMPL = 14;
    localparam int BIT_PAUSED = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Bits a status write may replace; one-time bits are only ever ORed in
    localparam logic [15:0] WRITABLE_MASK = 16'h43fc;
    localparam logic [15:0] OTP_MASK = 16'h3c00;
    // Array geometry in bytes
    localparam logic [19:0] ARRAY_BYTES = 20'h80000;
    localparam logic [19:0] BLOCK_BYTES = 20'h10000;
    localparam logic [19:0] SECTOR_BYTES = 20'h01000;
    // Instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE_A = 8'hc7;
    localparam logic [7:0] OP_CE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    // Address bits that pick one of the four security registers
    localparam int SEC_IDX_LO = 12;
    typedef enum {ST_IDLE, ST_BUSY, ST_PAUSED} fsw_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module fsw_prot_range #(
    parameter int ADDR_W = fsw_pkg::ADDR_W
) (
    input wire logic [2:0] rangeBits,
    input wire logic topBottom,
    input wire logic smallUnit,
    input wire logic complement,
    input wire logic [ADDR_W-1:0] addr,
    output logic addrProtected,
    output logic anyProtected
);
    // Size of the protected span before complementing; all-ones size means whole array
    function automatic logic [19:0] spanBytes(input logic [2:0] rb, input logic su);
        logic [19:0] s;
        s = 20'h00000;
        if (!su)
        begin
            if (rb[2])
                s = fsw_pkg::ARRAY_BYTES;
            else if (rb[1:0] != 2'b00)
                s = fsw_pkg::BLOCK_BYTES << (rb[1:0] - 2'd1);
        end
        else
        begin
            if (rb == 3'b111)
                s = fsw_pkg::ARRAY_BYTES;
            else if (rb[2])
                s = fsw_pkg::SECTOR_BYTES << 3;
            else if (rb[1:0] != 2'b00)
                s = fsw_pkg::SECTOR_BYTES << (rb[1:0] - 2'd1);
        end
        return s;
    endfunction

    logic [19:0] span;
    logic [19:0] addrExt;
    logic inSpan;

    always_comb
    begin
        span = spanBytes(rangeBits, smallUnit);
        addrExt = {{(20-ADDR_W){1'b0}}, addr};
        // Top spans start at array end minus size; bottom spans end at size
        if (topBottom)
            inSpan = addrExt < span;
        else
            inSpan = addrExt >= (fsw_pkg::ARRAY_BYTES - span);
        if (span == 20'h00000)
            inSpan = 1'b0;
        addrProtected = inSpan ^ complement;
        anyProtected = complement ? (span != fsw_pkg::ARRAY_BYTES) : (span != 20'h00000);
    end
endmodule

`default_nettype wire

// ==== logic/fsw_status_ctrl.sv ====
// Status register, write latch, lock modes and array write protection of a serial flash.
// Assumes an instruction decoder that hands over whole, byte-aligned instructions
// as one-cycle strobes, and an array engine that reports completion with opDone.

`timescale 1ns/1ps
`default_nettype none

module fsw_status_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic powerCycle,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [23:0] cmdAddr,
    input wire logic [15:0] cmdStatusData,
    input wire logic opDone,
    input wire logic writeProtectPin,
    output logic [7:0] statusLowByte,
    output logic [7:0] statusHighByte,
    output logic arrayStart,
    output logic cmdRefused,
    output logic quadPinsEnable
);
    logic wpMeta_r;
    logic wpSync_r;
    logic [15:0] stat_r;
    logic [15:0] stat_nxt;
    logic [15:0] pendData_r;
    logic [15:0] pendData_nxt;
    logic pendWrite_r;
    logic pendWrite_nxt;
    logic start_r;
    logic start_nxt;
    logic refused_r;
    logic refused_nxt;
    fsw_pkg::fsw_state_t state_r;
    fsw_pkg::fsw_state_t state_nxt;
    logic addrProt;
    logic anyProt;
    logic wpLevel;
    logic statusWritable;
    logic [1:0] lockMode;

    // Pin is asynchronous to core_clk
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wpMeta_r <= 1'b0;
            wpSync_r <= 1'b0;
        end
        else
        begin
            wpMeta_r <= writeProtectPin;
            wpSync_r <= wpMeta_r;
        end
    end

    fsw_prot_range #(
        .ADDR_W(fsw_pkg::ADDR_W)
    ) uRange (
        .rangeBits(stat_r[fsw_pkg::BIT_RANGE_LO +: 3]),
        .topBottom(stat_r[fsw_pkg::BIT_TOPBOT]),
        .smallUnit(stat_r[fsw_pkg::BIT_SMALLUNIT]),
        .complement(stat_r[fsw_pkg::BIT_COMPL]),
        .addr(cmdAddr[fsw_pkg::ADDR_W-1:0]),
        .addrProtected(addrProt),
        .anyProtected(anyProt)
    );

    function automatic logic isArrayWrite(input logic [7:0] c);
        return c == fsw_pkg::OP_PP || c == fsw_pkg::OP_QPP || c == fsw_pkg::OP_SE
            || c == fsw_pkg::OP_BE32 || c == fsw_pkg::OP_BE64;
    endfunction

    function automatic logic isChipErase(input logic [7:0] c);
        return c == fsw_pkg::OP_CE_A || c == fsw_pkg::OP_CE_B;
    endfunction

    function automatic logic isSecWrite(input logic [7:0] c);
        return c == fsw_pkg::OP_SEC_ERASE || c == fsw_pkg::OP_SEC_PROG;
    endfunction

    always_comb
    begin
        lockMode = {stat_r[fsw_pkg::BIT_LOCK_HI], stat_r[fsw_pkg::BIT_LOCK_LO]};
        // With quad lines active the pin carries data, so it cannot lock
        wpLevel = stat_r[fsw_pkg::BIT_QUAD] | wpSync_r;
        statusWritable = stat_r[fsw_pkg::BIT_WLATCH]
            && (lockMode == 2'b00 || (lockMode == 2'b01 && wpLevel));
    end

    always_comb
    begin
        stat_nxt = stat_r;
        pendData_nxt = pendData_r;
        pendWrite_nxt = pendWrite_r;
        state_nxt = state_r;
        start_nxt = 1'b0;
        refused_nxt = 1'b0;
        if (powerCycle)
        begin
            stat_nxt[fsw_pkg::BIT_WLATCH] = 1'b0;
            stat_nxt[fsw_pkg::BIT_PAUSED] = 1'b0;
            stat_nxt[fsw_pkg::BIT_BUSY] = 1'b0;
            if (lockMode == 2'b10)
            begin
                stat_nxt[fsw_pkg::BIT_LOCK_HI] = 1'b0;
                stat_nxt[fsw_pkg::BIT_LOCK_LO] = 1'b0;
            end
            pendWrite_nxt = 1'b0;
            state_nxt = fsw_pkg::ST_IDLE;
        end
        else
        begin
            case (state_r)
                fsw_pkg::ST_IDLE:
                begin
                    if (cmdValid)
                    begin
                        if (cmdCode == fsw_pkg::OP_WREN)
                            stat_nxt[fsw_pkg::BIT_WLATCH] = 1'b1;
                        else if (cmdCode == fsw_pkg::OP_WRDI)
                            stat_nxt[fsw_pkg::BIT_WLATCH] = 1'b0;
                        else if (cmdCode == fsw_pkg::OP_WRSR)
                        begin
                            if (statusWritable)
                            begin
                                pendWrite_nxt = 1'b1;
                                pendData_nxt = cmdStatusData;
                                stat_nxt[fsw_pkg::BIT_BUSY] = 1'b1;
                                state_nxt = fsw_pkg::ST_BUSY;
                            end
                            else
                                refused_nxt = 1'b1;
                        end
                        else if (isArrayWrite(cmdCode) || isChipErase(cmdCode)
                            || isSecWrite(cmdCode))
                        begin
                            if (!stat_r[fsw_pkg::BIT_WLATCH]
                                || (isArrayWrite(cmdCode) && addrProt)
                                || (isChipErase(cmdCode) && anyProt)
                                || (isSecWrite(cmdCode)
                                    && stat_r[fsw_pkg::BIT_OTP_LO
                                        + int'(cmdAddr[fsw_pkg::SEC_IDX_LO +: 2])]))
                                refused_nxt = 1'b1;
                            else
                            begin
                                start_nxt = 1'b1;
                                stat_nxt[fsw_pkg::BIT_BUSY] = 1'b1;
                                state_nxt = fsw_pkg::ST_BUSY;
                            end
                        end
                    end
                end
                fsw_pkg::ST_BUSY:
                begin
                    if (opDone)
                    begin
                        stat_nxt[fsw_pkg::BIT_BUSY] = 1'b0;
                        stat_nxt[fsw_pkg::BIT_WLATCH] = 1'b0;
                        if (pendWrite_r)
                        begin
                            // One-time bits can only be ORed in, never cleared
                            stat_nxt = (stat_nxt & ~fsw_pkg::WRITABLE_MASK & ~fsw_pkg::OTP_MASK)
                                | (pendData_r & fsw_pkg::WRITABLE_MASK)
                                | ((stat_r | pendData_r) & fsw_pkg::OTP_MASK);
                            stat_nxt[fsw_pkg::BIT_WLATCH] = 1'b0;
                            stat_nxt[fsw_pkg::BIT_BUSY] = 1'b0;
                            pendWrite_nxt = 1'b0;
                        end
                        state_nxt = fsw_pkg::ST_IDLE;
                    end
                    else if (cmdValid && cmdCode == fsw_pkg::OP_SUSPEND && !pendWrite_r)
                    begin
                        stat_nxt[fsw_pkg::BIT_PAUSED] = 1'b1;
                        stat_nxt[fsw_pkg::BIT_BUSY] = 1'b0;
                        state_nxt = fsw_pkg::ST_PAUSED;
                    end
                end
                fsw_pkg::ST_PAUSED:
                begin
                    if (cmdValid && cmdCode == fsw_pkg::OP_RESUME)
                    begin
                        stat_nxt[fsw_pkg::BIT_PAUSED] = 1'b0;
                        stat_nxt[fsw_pkg::BIT_BUSY] = 1'b1;
                        state_nxt = fsw_pkg::ST_BUSY;
                    end
                end
                default:
                    state_nxt = fsw_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stat_r <= fsw_pkg::STATUS_RESET;
            pendData_r <= 16'h0000;
            pendWrite_r <= 1'b0;
            state_r <= fsw_pkg::ST_IDLE;
            start_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            stat_r <= stat_nxt;
            pendData_r <= pendData_nxt;
            pendWrite_r <= pendWrite_nxt;
            state_r <= state_nxt;
            start_r <= start_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign statusLowByte = stat_r[7:0];
    assign statusHighByte = stat_r[15:8];
    assign arrayStart = start_r;
    assign cmdRefused = refused_r;
    assign quadPinsEnable = stat_r[fsw_pkg::BIT_QUAD];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic idleCmd;
    assign idleCmd = cmdValid && !powerCycle && state_r == fsw_pkg::ST_IDLE;

    AST_WREN_SETS: assert property (idleCmd && cmdCode == fsw_pkg::OP_WREN
        |=> stat_r[fsw_pkg::BIT_WLATCH])
        else $error("write enable did not set latch");
    AST_DONE_CLEARS: assert property (state_r == fsw_pkg::ST_BUSY && opDone
        && !powerCycle |=> !stat_r[fsw_pkg::BIT_WLATCH] && !stat_r[fsw_pkg::BIT_BUSY])
        else $error("completion left latch or busy set");
    AST_LOCKED_REFUSE: assert property (idleCmd && cmdCode == fsw_pkg::OP_WRSR
        && lockMode[1] |=> cmdRefused && $stable(stat_r))
        else $error("status write taken while locked");
    // Checked in the answering cycle only: a legal back-to-back command may follow it
    AST_PIN_REFUSE: assert property (idleCmd && cmdCode == fsw_pkg::OP_WRSR
        && lockMode == 2'b01 && !wpSync_r && !stat_r[fsw_pkg::BIT_QUAD]
        |=> cmdRefused && !stat_r[fsw_pkg::BIT_BUSY] && $stable(stat_r))
        else $error("status write taken with pin low");
    AST_SOFT_ACCEPT: assert property (idleCmd && cmdCode == fsw_pkg::OP_WRSR
        && lockMode == 2'b00 && stat_r[fsw_pkg::BIT_WLATCH]
        |=> stat_r[fsw_pkg::BIT_BUSY] && !cmdRefused)
        else $error("software mode refused status write");
    AST_POWER_UNLOCK: assert property (powerCycle && lockMode == 2'b10
        |=> stat_r[fsw_pkg::BIT_LOCK_HI +: 1] == 1'b0 && !stat_r[fsw_pkg::BIT_LOCK_LO])
        else $error("power cycle kept lock-down");
    AST_OTP_STICKY: assert property ($past(stat_r[13:10]) != 4'h0
        |-> (stat_r[13:10] & $past(stat_r[13:10])) == $past(stat_r[13:10]))
        else $error("one-time lock bit cleared");
    AST_SUSPEND: assert property (state_r == fsw_pkg::ST_BUSY && !pendWrite_r
        && cmdValid && cmdCode == fsw_pkg::OP_SUSPEND && !opDone && !powerCycle
        |=> stat_r[fsw_pkg::BIT_PAUSED] && !stat_r[fsw_pkg::BIT_BUSY])
        else $error("suspend not flagged");
    AST_PROT_BLOCK: assert property (idleCmd && isArrayWrite(cmdCode) && addrProt
        |=> cmdRefused && !arrayStart)
        else $error("write to protected address started");
    AST_BUSY_ONLY_OP: assert property (stat_r[fsw_pkg::BIT_BUSY]
        |-> state_r == fsw_pkg::ST_BUSY)
        else $error("busy flag without operation");
    AST_WRDI_CLEARS: assert property (idleCmd && cmdCode == fsw_pkg::OP_WRDI
        |=> !stat_r[fsw_pkg::BIT_WLATCH])
        else $error("write disable left latch set");
    AST_CHIP_PROT: assert property (idleCmd && isChipErase(cmdCode) && anyProt
        |=> cmdRefused && !arrayStart)
        else $error("chip erase started under protection");
    AST_RESUME: assert property (state_r == fsw_pkg::ST_PAUSED && cmdValid
        && cmdCode == fsw_pkg::OP_RESUME && !powerCycle
        |=> !stat_r[fsw_pkg::BIT_PAUSED] && stat_r[fsw_pkg::BIT_BUSY])
        else $error("resume did not restart operation");
    AST_POWER_CLEARS: assert property (powerCycle
        |=> !stat_r[fsw_pkg::BIT_WLATCH] && !stat_r[fsw_pkg::BIT_PAUSED]
        && state_r == fsw_pkg::ST_IDLE)
        else $error("power cycle left an operation running");

    COV_STATUS_WRITE: cover property (state_r == fsw_pkg::ST_BUSY && pendWrite_r && opDone);
    COV_PROG_DONE: cover property (arrayStart ##[1:20] opDone);
    COV_SUSPEND_RESUME: cover property (stat_r[fsw_pkg::BIT_PAUSED] ##[1:20]
        !stat_r[fsw_pkg::BIT_PAUSED]);
    COV_REFUSED: cover property (cmdRefused);
endmodule

`default_nettype wire

// ==== testbench/fsw_host_model.sv ====
// Host-side model: sends whole instructions as one-cycle strobes and stands in for the array engine.
// Assumes the status block shares core_clk and reports busy on status bit 0.
`timescale 1ns/1ps
`default_nettype none

module fsw_host_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic busy,
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic [23:0] cmdAddr,
    output logic [15:0] cmdStatusData,
    output logic opDone
);
    int doneDelay = 5;
    int cnt = 0;

    initial
    begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdAddr = 24'h000000;
        cmdStatusData = 16'h0000;
        opDone = 1'b0;
    end

    // Quad bit is set only while the protect and hold pins are free here
    task automatic issue(input logic [7:0] code, input logic [23:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdAddr <= addr;
        cmdStatusData <= data;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        // Released lines show the inverse so a stale value never looks fresh
        cmdCode <= ~code;
        cmdAddr <= ~addr;
        cmdStatusData <= ~data;
    endtask

    // Array engine: finishes a running operation after doneDelay+1 busy cycles
    always @(posedge core_clk)
    begin
        opDone <= 1'b0;
        if (rst || !busy)
            cnt <= 0;
        else if (cnt >= doneDelay)
        begin
            opDone <= 1'b1;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

`default_nettype wire

// ==== testbench/tb_flash_status_write_protect.sv ====
// Self-checking bench of the status and write-protect block.
// Assumes the host model drives instructions and opDone; the bench drives pins and power cycles.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb_flash_status_write_protect;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic powerCycle = 1'b0;
    logic wpPin = 1'b0;
    logic cmdValid, opDone, arrayStart, cmdRefused, quadPinsEnable;
    logic [7:0] cmdCode, sLo, sHi;
    logic [23:0] cmdAddr;
    logic [15:0] cmdStatusData;
    int mismatches = 0;
    int numChecks = 0;
    // Rows: status word written, program address, refusal expected
    localparam logic [40:0] ROWS [19] = '{
        {16'h0000, 24'h07ffff, 1'b0}, {16'h0004, 24'h070000, 1'b1}, {16'h0004, 24'h06ffff, 1'b0},
        {16'h0028, 24'h01ffff, 1'b1}, {16'h0028, 24'h020000, 1'b0}, {16'h000c, 24'h040000, 1'b1},
        {16'h0010, 24'h000000, 1'b1}, {16'h0044, 24'h07f000, 1'b1}, {16'h0044, 24'h07efff, 1'b0},
        {16'h006c, 24'h003fff, 1'b1}, {16'h006c, 24'h004000, 1'b0}, {16'h0054, 24'h078000, 1'b1},
        {16'h005c, 24'h000000, 1'b1}, {16'h4044, 24'h07f000, 1'b0}, {16'h4044, 24'h07efff, 1'b1},
        {16'h402c, 24'h03ffff, 1'b0}, {16'h402c, 24'h040000, 1'b1}, {16'h4000, 24'h000000, 1'b1},
        {16'h4010, 24'h000000, 1'b0}};
    localparam logic [7:0] OPS [8] = '{fsw_pkg::OP_PP, fsw_pkg::OP_QPP, fsw_pkg::OP_SE,
        fsw_pkg::OP_BE32, fsw_pkg::OP_BE64, fsw_pkg::OP_CE_A, fsw_pkg::OP_CE_B,
        fsw_pkg::OP_SEC_ERASE};

    always #2 core_clk = ~core_clk;

    fsw_status_ctrl fsw_status_ctrl_i (
        .core_clk(core_clk), .rst(rst), .powerCycle(powerCycle), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdStatusData(cmdStatusData), .opDone(opDone),
        .writeProtectPin(wpPin), .statusLowByte(sLo), .statusHighByte(sHi),
        .arrayStart(arrayStart), .cmdRefused(cmdRefused), .quadPinsEnable(quadPinsEnable));

    fsw_host_model fsw_host_model_i (
        .core_clk(core_clk), .rst(rst), .busy(sLo[0]), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdAddr(cmdAddr), .cmdStatusData(cmdStatusData), .opDone(opDone));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Returns just after the answering edge, while the one-cycle pulses still stand
    task automatic cmd(input logic [7:0] code, input logic [23:0] addr, input logic [15:0] data);
        fsw_host_model_i.issue(code, addr, data);
        #1;
    endtask

    task automatic waitIdle;
        int n;
        n = 0;
        while (sLo[0] !== 1'b0 && n < 300)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("busy clear", 1'b0, sLo[0])
    endtask

    task automatic wrsr(input logic [15:0] data);
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_WRSR, 24'h000000, data);
    endtask

    task automatic pulsePower;
        @(posedge core_clk);
        powerCycle <= 1'b1;
        @(posedge core_clk);
        powerCycle <= 1'b0;
        #1;
    endtask

    // Pin passes a two-stage synchroniser, so give it a few edges
    task automatic setPin(input logic v);
        @(posedge core_clk);
        wpPin <= v;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        wrap_up;
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        `CHK("reset low", 8'h00, sLo)
        `CHK("reset high", 8'h00, sHi)
        `CHK("quad reset", 1'b0, quadPinsEnable)
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        `CHK("latch set", 1'b1, sLo[1])
        cmd(fsw_pkg::OP_WRDI, 24'h000000, 16'h0000);
        `CHK("latch wrdi", 1'b0, sLo[1])
        cmd(fsw_pkg::OP_WRSR, 24'h000000, 16'h0004);
        `CHK("wrsr no latch", 1'b1, cmdRefused)
        `CHK("unchanged", 8'h00, sLo)
        foreach (ROWS[i])
        begin
            wrsr(ROWS[i][40:25]);
            waitIdle;
            `CHK("status", ROWS[i][40:25], {sHi, sLo})
            cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
            cmd(fsw_pkg::OP_PP, ROWS[i][24:1], 16'h0000);
            `CHK("refused", ROWS[i][0], cmdRefused)
            `CHK("started", ~ROWS[i][0], arrayStart)
            waitIdle;
        end
        wrsr(16'h0000);
        waitIdle;
        foreach (OPS[i])
        begin
            cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
            cmd(OPS[i], 24'h000000, 16'h0000);
            `CHK("op start", 1'b1, arrayStart)
            `CHK("busy set", 1'b1, sLo[0])
            waitIdle;
            `CHK("latch op", 1'b0, sLo[1])
        end
        wrsr(16'h0044);
        waitIdle;
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_CE_B, 24'h000000, 16'h0000);
        `CHK("chip prot", 1'b1, cmdRefused)
        wrsr(16'h405c);
        waitIdle;
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_CE_A, 24'h000000, 16'h0000);
        `CHK("chip cmp none", 1'b1, arrayStart)
        waitIdle;
        fsw_host_model_i.doneDelay = 40;
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_PP, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_SUSPEND, 24'h000000, 16'h0000);
        `CHK("paused", 1'b1, sHi[7])
        cmd(fsw_pkg::OP_RESUME, 24'h000000, 16'h0000);
        `CHK("resumed", 1'b0, sHi[7])
        `CHK("busy resume", 1'b1, sLo[0])
        cmd(fsw_pkg::OP_SUSPEND, 24'h000000, 16'h0000);
        pulsePower;
        `CHK("paused power", 1'b0, sHi[7])
        `CHK("latch power", 1'b0, sLo[1])
        fsw_host_model_i.doneDelay = 5;
        wrsr(16'h0080);
        waitIdle;
        wrsr(16'h0084);
        `CHK("pin low", 1'b1, cmdRefused)
        `CHK("range kept", 3'b000, sLo[4:2])
        setPin(1'b1);
        wrsr(16'h0004);
        waitIdle;
        `CHK("pin high", 16'h0004, {sHi, sLo})
        setPin(1'b0);
        wrsr(16'h0100);
        waitIdle;
        wrsr(16'h0000);
        `CHK("lockdown", 1'b1, cmdRefused)
        pulsePower;
        `CHK("lock cleared", 1'b0, sHi[0])
        wrsr(16'h0600);
        waitIdle;
        `CHK("quad on", 1'b1, quadPinsEnable)
        `CHK("otp set", 1'b1, sHi[2])
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_SEC_PROG, 24'h000000, 16'h0000);
        `CHK("otp locked", 1'b1, cmdRefused)
        cmd(fsw_pkg::OP_WREN, 24'h000000, 16'h0000);
        cmd(fsw_pkg::OP_SEC_PROG, 24'h001000, 16'h0000);
        `CHK("otp open", 1'b1, arrayStart)
        waitIdle;
        wrsr(16'h0000);
        waitIdle;
        `CHK("otp stays", 8'h04, sHi)
        `CHK("quad off", 1'b0, quadPinsEnable)
        // Pin is low here; with quad lines on it must not lock the status register
        wrsr(16'h0280);
        waitIdle;
        wrsr(16'h0000);
        waitIdle;
        `CHK("quad pin free", 16'h0400, {sHi, sLo})
        wrsr(16'h0180);
        waitIdle;
        wrsr(16'h0000);
        `CHK("permanent", 1'b1, cmdRefused)
        pulsePower;
        `CHK("lock stays", 2'b11, {sHi[0], sLo[7]})
        wrap_up;
    end
endmodule

`default_nettype wire
